/* inc/lre_pkg.sv */
/*
  shared constants and types of the lighting ramp executor:
  instruction field positions, divider ratios, register offset,
  request and variable carriers, core state and one-hot states.
  assumes a 16-bit instruction word and eleven mapped outputs.
*/
`default_nettype none

package lre_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_OUT = 11;           // ten led sinks plus haptic

  // ==========================================================
  // register map
  localparam logic [7:0] VAR_D_ADDR = 8'h3c;   // global_ramp_variable
  localparam logic [7:0] VAR_D_RESET = 8'h00;  // value after reset

  // ==========================================================
  // instruction fields
  localparam int PRESCALE_BIT = 14;      // tick select
  localparam int STEP_TIME_HI = 13;      // step time msb
  localparam int STEP_TIME_LO = 9;       // step time lsb
  localparam int SIGN_BIT = 8;           // 0 up, 1 down
  localparam int INC_HI = 7;             // increment count msb
  localparam int INC_LO = 0;             // increment count lsb
  localparam int FAST_SIZE_HI = 7;       // fast step size code msb
  localparam int FAST_SIZE_LO = 6;       // fast step size code lsb
  localparam int FAST_CNT_HI = 5;        // fast step count msb
  localparam int FAST_CNT_LO = 0;        // fast step count lsb
  localparam int VAR_TIME_HI = 3;        // step time selector msb
  localparam int VAR_TIME_LO = 2;        // step time selector lsb
  localparam int VAR_CNT_HI = 1;         // step count selector msb
  localparam int VAR_CNT_LO = 0;         // step count selector lsb

  // ==========================================================
  // timing, in master clock ticks (32.768 khz)
  localparam logic [8:0] DIV_FAST = 9'h010;    // 16 -> 0.488 ms
  localparam logic [8:0] DIV_SLOW = 9'h200;    // 512 -> 15.625 ms
  localparam logic [4:0] FAST_SPAN = 5'h01;    // one fast tick a step

  // ==========================================================
  // kinds of ramp request
  typedef enum logic [1:0] {
    KIND_RAMP = 2'h0,                    // numeric operands
    KIND_FAST = 2'h1,                    // fast ramp
    KIND_VAR = 2'h2                      // variable operands
  } lre_kind_type;

  // request from the engine sequencer
  typedef struct packed {
    logic valid;                         // start pulse
    lre_kind_type kind;                  // which ramp
    logic [15:0] word;                   // instruction word
  } lre_req_type;

  // local and engine variables
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } lre_vars_type;

  // one-hot states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } lre_state_type;

  // complete state of the executor
  typedef struct packed {
    lre_state_type state;                // sequence state
    logic [NUM_OUT-1:0][7:0] level;      // linear ramp level
    logic [NUM_OUT-1:0][7:0] brgt;       // driven brightness
    logic [NUM_OUT-1:0] we;              // brightness write pulses
    logic done;                          // completion pulse
    logic sign;                          // direction
    logic absolute;                      // load instead of step
    logic [7:0] delta;                   // change per step
    logic [7:0] steps;                   // steps still to run
    logic [4:0] span;                    // prescaled ticks a step
    logic slow;                          // 512 divider selected
    logic [8:0] mcnt;                    // master ticks in tick
    logic [4:0] pcnt;                    // prescaled ticks in step
    logic [7:0] var_d;                   // global_ramp_variable
  } lre_core_type;

endpackage

`default_nettype wire

/* rtl/lre_chan.sv */
/*
  per-output step arithmetic: saturating add or subtract, absolute
  load, and the logarithmic display curve.
  assumes purely combinational use from the executor's state.
*/
`timescale 1ns/1ps
`default_nettype none

module lre_chan (
  input wire logic [7:0] level_i,        // present linear level
  input wire logic [7:0] delta_i,        // change this step
  input wire logic sign_i,               // 1 lowers
  input wire logic absolute_i,           // load delta as level
  input wire logic log_en_i,             // logarithmic curve
  output logic [7:0] level_o,            // next linear level
  output logic [7:0] brgt_o              // next driven value
);
  import lre_pkg::*;

  // ==========================================================
  // step arithmetic
  logic [8:0] sum;                       // widened sum
  logic [15:0] sq;                       // square for curve

  // add or subtract, clamped at 0 and 255
  always_comb begin
    sum = {1'b0, level_i} + {1'b0, delta_i};
    if (absolute_i) begin
      level_o = delta_i;
    end else if (sign_i) begin
      level_o = (level_i > delta_i) ? 8'(level_i - delta_i) : 8'h00;
    end else begin
      level_o = sum[8] ? 8'hff : sum[7:0];
    end
  end

  // ==========================================================
  // display curve: square law keeps 0 and 255 fixed
  always_comb begin
    sq = 16'(level_o) * 16'(level_o) + 16'h00ff;
    brgt_o = log_en_i ? sq[15:8] : level_o;
  end

endmodule

`default_nettype wire

/* rtl/lre_ramp_exec.sv */
/*
  ramp execution unit of a lighting engine: standard, fast and
  variable-operand brightness ramps over the mapped outputs.
  assumes the sequencer holds off a new request until completion,
  the master tick is a one-cycle pulse at 32.768 khz, and all
  inputs but RSTN_I are synchronous to SYS_CLK_I (40 mhz).
*/
`timescale 1ns/1ps
`default_nettype none

module lre_ramp_exec (
  input wire logic SYS_CLK_I,                      // 40 mhz clock
  input wire logic RSTN_I,                         // async reset, low
  input wire logic MCLK_TICK_I,                    // 32.768 khz tick
  input wire lre_pkg::lre_req_type REQ_I,          // ramp request
  input wire lre_pkg::lre_vars_type VARS_I,        // variables a-c
  input wire logic [lre_pkg::NUM_OUT-1:0] MAP_I,   // active mapping
  input wire logic [lre_pkg::NUM_OUT-1:0][7:0] EFF_BRGT_I, // now
  input wire logic LOG_EN_I,                       // log curve select
  input wire logic ADC_SEL_I,                      // d from converter
  input wire logic [7:0] ADC_VALUE_I,              // converter result
  input wire logic REG_WR_I,                       // register write
  input wire logic [7:0] REG_ADDR_I,               // register address
  input wire logic [7:0] REG_WDATA_I,              // write data
  output logic [7:0] REG_RDATA_O,                  // read data
  output logic BUSY_O,                             // ramp running
  output logic DONE_O,                             // completion pulse
  output logic [lre_pkg::NUM_OUT-1:0] BRGT_WE_O,   // write pulses
  output logic [lre_pkg::NUM_OUT-1:0][7:0] BRGT_O  // brightness
);
  import lre_pkg::*;

  // ==========================================================
  // declarations
  lre_core_type core_reg;                // registered state
  lre_core_type core_next;               // next state
  logic [NUM_OUT-1:0][7:0] chan_level;   // per output next level
  logic [NUM_OUT-1:0][7:0] chan_brgt;    // per output next value
  logic [7:0] var_d;                     // effective variable d
  logic [7:0] op_time;                   // selected step time
  logic [7:0] op_cnt;                    // selected step count
  logic [4:0] st_time;                   // step time field
  logic [7:0] st_inc;                    // increment count
  logic [8:0] div;                       // active tick divider
  logic tick_end;                        // prescaled tick boundary
  logic step_end;                        // step boundary

  // ==========================================================
  // variable selection

  // d comes from the register or from the converter
  always_comb begin
    var_d = ADC_SEL_I ? ADC_VALUE_I : core_reg.var_d;
  end

  // selector decode for the variable-operand ramp
  function automatic logic [7:0] pick_var(
    input logic [1:0] sel,
    input lre_vars_type v,
    input logic [7:0] d
  );
    logic [7:0] r;
    r = 8'h00;
    unique case (sel)
      2'h0: r = v.a;
      2'h1: r = v.b;
      2'h2: r = v.c;
      2'h3: r = d;
    endcase
    return r;
  endfunction

  // operands for a standard or variable ramp
  always_comb begin
    op_time = pick_var(REQ_I.word[VAR_TIME_HI:VAR_TIME_LO], VARS_I,
                       var_d);
    op_cnt = pick_var(REQ_I.word[VAR_CNT_HI:VAR_CNT_LO], VARS_I,
                      var_d);
    if (REQ_I.kind == KIND_VAR) begin
      st_time = op_time[4:0];
      st_inc = op_cnt;
    end else begin
      st_time = REQ_I.word[STEP_TIME_HI:STEP_TIME_LO];
      st_inc = REQ_I.word[INC_HI:INC_LO];
    end
  end

  // ==========================================================
  // per-output arithmetic
  generate
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_chan
      lre_chan u_chan (
        .level_i(core_reg.level[i]),
        .delta_i(core_reg.delta),
        .sign_i(core_reg.sign),
        .absolute_i(core_reg.absolute),
        .log_en_i(LOG_EN_I),
        .level_o(chan_level[i]),
        .brgt_o(chan_brgt[i])
      );
    end
  endgenerate

  // ==========================================================
  // step timing

  // tick and step boundaries from the master tick
  always_comb begin
    div = core_reg.slow ? DIV_SLOW : DIV_FAST;
    tick_end = MCLK_TICK_I && (core_reg.mcnt == 9'(div - 9'h001));
    step_end = tick_end &&
               (core_reg.pcnt == 5'(core_reg.span - 5'h01));
  end

  // ==========================================================
  // next state
  always_comb begin
    core_next = core_reg;
    core_next.we = '0;                   // pulses last one cycle
    core_next.done = 1'b0;
    // register write, the only writable location
    if (REG_WR_I && (REG_ADDR_I == VAR_D_ADDR)) begin
      core_next.var_d = REG_WDATA_I;
    end
    unique case (core_reg.state)
      ST_IDLE: begin
        if (REQ_I.valid) begin
          core_next.state = ST_RUN;
          core_next.mcnt = 9'h000;
          core_next.pcnt = 5'h00;
          core_next.level = EFF_BRGT_I;
          core_next.sign = REQ_I.word[SIGN_BIT];
          core_next.absolute = 1'b0;
          if (REQ_I.kind == KIND_FAST) begin
            // fast ramp: operands only from the word
            core_next.slow = 1'b0;
            core_next.span = FAST_SPAN;
            core_next.delta = 8'h02 <<
              REQ_I.word[FAST_SIZE_HI:FAST_SIZE_LO];
            core_next.steps =
              {2'h0, REQ_I.word[FAST_CNT_HI:FAST_CNT_LO]};
            if (REQ_I.word[FAST_CNT_HI:FAST_CNT_LO] == 6'h00) begin
              core_next.steps = 8'h01;   // no count: one idle step
              core_next.delta = 8'h00;
            end
          end else if (st_time == 5'h00) begin
            // zero step time: one fast period, set relative/absolute
            core_next.slow = 1'b0;
            core_next.span = FAST_SPAN;
            core_next.steps = 8'h01;
            core_next.delta = st_inc;
            core_next.absolute = REQ_I.word[PRESCALE_BIT];
          end else begin
            // standard ramp, one unit per step
            core_next.slow = REQ_I.word[PRESCALE_BIT];
            core_next.span = st_time;
            if (st_inc == 8'h00) begin
              core_next.steps = 8'h01;
              core_next.delta = 8'h00;
            end else begin
              core_next.steps = st_inc;
              core_next.delta = 8'h01;
            end
          end
        end
      end
      ST_RUN: begin
        // count master ticks within a prescaled tick
        if (MCLK_TICK_I) begin
          core_next.mcnt = tick_end ? 9'h000 : 9'(core_reg.mcnt + 9'h001);
        end
        if (tick_end) begin
          core_next.pcnt = 5'(core_reg.pcnt + 5'h01);
        end
        if (step_end) begin
          core_next.pcnt = 5'h00;
          // apply the step to mapped outputs only
          for (int i = 0; i < NUM_OUT; i++) begin
            if (MAP_I[i]) begin
              core_next.level[i] = chan_level[i];
              core_next.brgt[i] = chan_brgt[i];
              core_next.we[i] = 1'b1;
            end
          end
          // saturated or not, every step is timed out
          if (core_reg.steps == 8'h01) begin
            core_next.state = ST_DONE;
            core_next.done = 1'b1;
          end else begin
            core_next.steps = 8'(core_reg.steps - 8'h01);
          end
        end
      end
      ST_DONE: begin
        // one settling cycle so a new request follows the pulse
        core_next.state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      core_reg <= '0;
      core_reg.state <= ST_IDLE;
      core_reg.var_d <= VAR_D_RESET;
      core_reg.span <= FAST_SPAN;
      core_reg.steps <= 8'h01;
    end else begin
      core_reg <= core_next;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    REG_RDATA_O = (REG_ADDR_I == VAR_D_ADDR) ? core_reg.var_d : 8'h00;
    BUSY_O = (core_reg.state != ST_IDLE);
    DONE_O = core_reg.done;
    BRGT_WE_O = core_reg.we;
    BRGT_O = core_reg.brgt;
  end

endmodule

`default_nettype wire

/* test/lre_ramp_monitor.sv */
/*
  port checker of the ramp executor.
  assumes it is bound into lre_ramp_exec.
*/
`timescale 1ns/1ps
`default_nettype none

module lre_ramp_monitor
  import lre_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire lre_pkg::lre_req_type REQ_I,
  input wire logic [lre_pkg::NUM_OUT-1:0] MAP_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic [lre_pkg::NUM_OUT-1:0] BRGT_WE_O,
  input wire logic [lre_pkg::NUM_OUT-1:0][7:0] BRGT_O
);
  // ==========================================================
  // clocking and sequences
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // busy with the completion pulse, idle and quiet one cycle later
  sequence finish_s;
    BUSY_O ##1 (!BUSY_O && !DONE_O);
  endsequence

  // no step and no completion for eight cycles
  sequence quiet_s;
    (!DONE_O && BRGT_WE_O == '0) [*8];
  endsequence

  // ==========================================================
  // assertions
  done_pulse_a: assert property (DONE_O |-> finish_s)
    else $error("completion pulse malformed");
  start_quiet_a: assert property (
    REQ_I.valid && !BUSY_O |=> BUSY_O ##0 quiet_s)
    else $error("step too soon after start");
  step_gap_a: assert property (|BRGT_WE_O |=> quiet_s)
    else $error("steps too close together");
  mapped_only_a: assert property (
    |BRGT_WE_O |-> (BRGT_WE_O & ~$past(MAP_I)) == '0)
    else $error("unmapped output written");
  idle_still_a: assert property (
    !BUSY_O |-> $stable(BRGT_O) && BRGT_WE_O == '0)
    else $error("brightness moved while idle");
  busy_hold_a: assert property (BUSY_O && !DONE_O |=> BUSY_O)
    else $error("ramp ended without completion");
  rise_cause_a: assert property ($rose(BUSY_O) |-> $past(REQ_I.valid))
    else $error("ramp started without request");
  unmapped_read_a: assert property (
    REG_ADDR_I != VAR_D_ADDR |-> REG_RDATA_O == 8'h00)
    else $error("unmapped address reads nonzero");
  reg_write_a: assert property (REG_WR_I && REG_ADDR_I == VAR_D_ADDR
    |=> REG_ADDR_I != VAR_D_ADDR || REG_RDATA_O == $past(REG_WDATA_I))
    else $error("variable register lost write");
endmodule

`default_nettype wire

/* test/lre_led_model.sv */
/*
  brightness registers behind the executor.
  assumes the bench may preload every output at once.
*/
`timescale 1ns/1ps
`default_nettype none

module lre_led_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,                         // preload all
  input wire logic [7:0] load_val_i,               // preload value
  input wire logic [lre_pkg::NUM_OUT-1:0] we_i,    // write pulses
  input wire logic [lre_pkg::NUM_OUT-1:0][7:0] brgt_i,
  output logic [lre_pkg::NUM_OUT-1:0][7:0] eff_o  // effective level
);
  import lre_pkg::*;

  // ==========================================================
  // registers take the preload, else only written outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eff_o <= '0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (load_i) begin
          eff_o[i] <= load_val_i;
        end else if (we_i[i]) begin
          eff_o[i] <= brgt_i[i];
        end
      end
    end
  end
endmodule

`default_nettype wire

/* test/tb_lighting_ramp_executor.sv */
/*
  self-checking bench of the ramp executor.
  assumes a master tick every second clock and the brightness model.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_lighting_ramp_executor;
  import lre_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tick = 1'b0;                     // master tick
  lre_req_type req = '0;
  lre_vars_type vars = '0;
  logic [NUM_OUT-1:0] map = '1;
  logic log_en = 1'b0;
  logic adc_sel = 1'b0;
  logic [7:0] adc_val = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic ld = 1'b0;                       // model preload
  logic [7:0] ld_val = 8'h00;
  logic [7:0] rdata;
  logic busy;
  logic done;
  logic [NUM_OUT-1:0] we;
  logic [NUM_OUT-1:0][7:0] brgt;
  logic [NUM_OUT-1:0][7:0] eff;
  int mismatches = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;
  always @(negedge clk) tick <= ~tick;

  lre_ramp_exec DUT (.SYS_CLK_I(clk), .RSTN_I(rstn), .MCLK_TICK_I(tick),
    .REQ_I(req), .VARS_I(vars), .MAP_I(map), .EFF_BRGT_I(eff),
    .LOG_EN_I(log_en), .ADC_SEL_I(adc_sel), .ADC_VALUE_I(adc_val),
    .REG_WR_I(reg_wr), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_RDATA_O(rdata), .BUSY_O(busy), .DONE_O(done),
    .BRGT_WE_O(we), .BRGT_O(brgt));
  lre_led_model LEDS (.clk_i(clk), .rstn_i(rstn), .load_i(ld),
    .load_val_i(ld_val), .we_i(we), .brgt_i(brgt), .eff_o(eff));

  // ==========================================================
  // reporting and expectations
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_dur(input int got, input int ticks);
    total_checks++;
    if (got < 2 * ticks - 4 || got > 2 * ticks + 4) begin
      mismatches++;
      $display("unexpected at %0t: %0d cycles", $time, got);
    end
  endtask
  function automatic logic [7:0] logf(input int l);
    return 8'((l * l + 255) >> 8);
  endfunction

  // ==========================================================
  // bus and ramp drivers
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr <= a;
    #1 chk_val(rdata, exp);
  endtask
  task automatic ramp_case(input lre_kind_type k, input logic [15:0] w,
      input logic [7:0] st, input logic [7:0] exp, input int ticks);
    int n;
    logic [NUM_OUT-1:0] m;
    m = NUM_OUT'($urandom) | 11'h001;
    @(negedge clk);
    map <= m;
    ld <= 1'b1;
    ld_val <= st;
    @(negedge clk);
    ld <= 1'b0;
    req <= '{1'b1, k, w};
    @(negedge clk);
    req.valid <= 1'b0;
    // operands change after the start edge
    vars <= 24'($urandom);
    adc_val <= 8'($urandom);
    reg_wr <= (k == KIND_VAR);
    reg_addr <= VAR_D_ADDR;
    reg_wdata <= 8'($urandom);
    n = 1;
    // an unknown completion flag must not pass as finished
    while (done !== 1'b1 && n < 20000) begin
      @(negedge clk);
      reg_wr <= 1'b0;
      n++;
    end
    if (done !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no completion", $time);
      conclude();
    end
    chk_dur(n, ticks);
    repeat (2) @(negedge clk);
    for (int i = 0; i < NUM_OUT; i++) begin
      chk_val(eff[i], m[i] ? exp : st);
    end
    $display("test done: word %h", w);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int s;
    int v[4];
    logic [7:0] st;
    s = $urandom(45756);
    repeat (8) @(negedge clk);
    rstn <= 1'b1;
    reg_read(VAR_D_ADDR, VAR_D_RESET);
    reg_write(VAR_D_ADDR, 8'h5a);
    reg_read(VAR_D_ADDR, 8'h5a);
    reg_write(8'h3d, 8'h11);
    reg_read(8'h3d, 8'h00);
    $display("test done: register access");
    st = 8'($urandom_range(200));
    ramp_case(KIND_RAMP, 16'h0203, st, st + 8'h03, 48);
    ramp_case(KIND_RAMP, 16'h0503, 8'h01, 8'h00, 96);
    ramp_case(KIND_RAMP, 16'h0203, 8'hfe, 8'hff, 48);
    ramp_case(KIND_RAMP, 16'h0600, st, st, 48);
    ramp_case(KIND_RAMP, 16'h0114, 8'h32, 8'h1e, 16);
    ramp_case(KIND_RAMP, 16'h404d, 8'h32, 8'h4d, 16);
    ramp_case(KIND_RAMP, 16'h4201, st, st + 8'h01, 512);
    ramp_case(KIND_RAMP, 16'h02ff, 8'h00, 8'hff, 4080);
    for (int c = 0; c < 4; c++) begin
      ramp_case(KIND_FAST, 16'(c << 6 | 3), 8'h40,
        8'(64 + 3 * (2 << c)), 48);
    end
    ramp_case(KIND_FAST, 16'h7fff, 8'hff, 8'h00, 1008);
    log_en <= 1'b1;
    ramp_case(KIND_FAST, 16'h0001, 8'h40, logf(66), 16);
    log_en <= 1'b0;
    for (s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        v[c] = $urandom_range(3) + 1;
      end
      vars <= {8'(v[0]), 8'(v[1]), 8'(v[2])};
      adc_sel <= (s == 3);
      adc_val <= 8'(v[3]);
      reg_write(VAR_D_ADDR, 8'(v[3]));
      ramp_case(KIND_VAR, 16'(s << 2 | (s + 1) % 4), 8'h20,
        8'(32 + v[(s + 1) % 4]), v[s] * 16 * v[(s + 1) % 4]);
    end
    conclude();
  end
endmodule

bind lre_ramp_exec lre_ramp_monitor MON (.SYS_CLK_I(SYS_CLK_I),
  .RSTN_I(RSTN_I), .REQ_I(REQ_I), .MAP_I(MAP_I), .REG_WR_I(REG_WR_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_RDATA_O(REG_RDATA_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
  .BRGT_WE_O(BRGT_WE_O), .BRGT_O(BRGT_O));

`default_nettype wire
